/* File: ee_i2c_client.sv */
// Two-wire serial EEPROM client with page buffer and APB status access
//
// Behaviour
// - The three unused address pins have no effect on anything.
// - Write-protect high inhibits every array write; reads stay unaffected.
// - SDA changes only while SCL low; changes with SCL high are Start/Stop.
// - SDA falling while SCL high is a Start; every command begins so.
// - SDA rising while SCL high is a Stop; every operation ends so.
// - Receiver acknowledges each byte on a ninth host clock pulse.
// - No acknowledge at all while a programming cycle runs.
// - Acknowledge holds SDA low through the whole ninth clock high phase.
// - Host withholds acknowledge after last read byte; device releases SDA.
// - First four bits after Start must match the device code.
// - Two bits ignored; block select becomes word address MSB.
// - Eighth control bit: one means read, zero means write.
// - Matching control byte is acknowledged, then read or write follows.
// - Byte after write control byte is the low eight bits of the word address.
// - Byte write: control, address, data, each acknowledged; Stop starts cycle.
// - Page write buffers up to 16 bytes, committed only after Stop.
// - Each data byte advances only the low four pointer bits.
// - Beyond 16 bytes the pointer rolls over, keeping the last sixteen.
// - Page writes wrap inside the current page, never into the next.
// - Array starts with every location all ones.
// - Write-direction polling is refused while busy, acknowledged after.
// - Pointer holds last accessed word plus one for current reads.
// - Host acknowledge during read advances pointer and sends next byte.
`timescale 1ns/1ps

module ee_i2c_client
  import ee_pkg::*;
#(
  parameter int unsigned TWC_CYCLES = TWC_CYC,
  parameter logic [3:0]  DEV_CODE   = 4'h6  // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_b,
  input  wire logic        wp,
  input  wire logic        unused_addr_pin_0,
  input  wire logic        unused_addr_pin_1,
  input  wire logic        unused_addr_pin_2
);

  localparam int unsigned CW = $clog2(TWC_CYCLES + 1);

  // ==========================================================================
  // Line synchronisers and condition detection
  ee_line_s   ln_s1;
  ee_line_s   ln_s2;
  ee_line_s   ln_d;
  logic       wp_s1;
  logic       wp_s2;

  // Reset to idle-high levels so no false edge follows reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ln_s1 <= '{scl: 1'b1, sda: 1'b1};
      ln_s2 <= '{scl: 1'b1, sda: 1'b1};
      ln_d  <= '{scl: 1'b1, sda: 1'b1};
      wp_s1 <= 1'b0;
      wp_s2 <= 1'b0;
    end else if (ce) begin
      ln_s1 <= '{scl: scl_i, sda: sda_i};
      ln_s2 <= ln_s1;
      ln_d  <= ln_s2;
      wp_s1 <= wp;
      wp_s2 <= wp_s1;
    end
  end

  logic start_c;
  logic stop_c;
  logic scl_rise;
  logic scl_fall;

  // SDA edge while SCL stays high is a condition, not data
  assign start_c  = ln_d.scl & ln_s2.scl & ln_d.sda & ~ln_s2.sda;
  assign stop_c   = ln_d.scl & ln_s2.scl & ~ln_d.sda & ln_s2.sda;
  assign scl_rise = ln_s2.scl & ~ln_d.scl;
  assign scl_fall = ~ln_s2.scl & ln_d.scl;

  // ==========================================================================
  // Protocol state
  ee_state_e  state;
  ee_kind_e   kind;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic [8:0] ptr;
  logic       rw;
  logic       pend;
  logic       busy;
  logic [CW-1:0] busy_cnt;
  logic       resp_en;
  logic [7:0] mem [MEM_WORDS];
  logic [7:0] pbuf [PAGE_SIZE];
  logic [PAGE_SIZE-1:0] mask;

  logic       rx_done;
  logic       code_ok;
  logic       ctrl_ok;
  logic       data_take;
  logic       commit;
  logic [7:0] tx_byte;

  assign rx_done   = (state == ST_RX) && scl_fall && (bit_cnt == 4'h8);
  // Match looks at the code bits alone; address pins play no part
  assign code_ok   = (shreg[7:4] == DEV_CODE);
  // Busy refuses even the own address
  assign ctrl_ok   = (kind == K_CTRL) && code_ok && !busy && resp_en;
  assign data_take = rx_done && (kind == K_DATA);
  assign commit    = stop_c && pend;
  assign tx_byte   = mem[ptr];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= ST_IDLE;
      kind     <= K_CTRL;
      shreg    <= 8'h00;
      bit_cnt  <= 4'h0;
      ptr      <= 9'h000;
      rw       <= 1'b0;
      pend     <= 1'b0;
      sda_oe_b <= 1'b1;
    end else if (ce) begin
      if (start_c) begin
        // Repeated Start abandons a pending write
        state    <= ST_RX;
        kind     <= K_CTRL;
        bit_cnt  <= 4'h0;
        pend     <= 1'b0;
        sda_oe_b <= 1'b1;
      end else if (stop_c) begin
        state    <= ST_IDLE;
        pend     <= 1'b0;
        sda_oe_b <= 1'b1;
      end else begin
        unique case (state)
          ST_IDLE: begin
            sda_oe_b <= 1'b1;
          end
          ST_RX: begin
            if (scl_rise && bit_cnt != 4'h8) begin
              shreg   <= {shreg[6:0], ln_s2.sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (rx_done) begin
              unique case (kind)
                K_CTRL: begin
                  if (ctrl_ok) begin
                    rw       <= shreg[0];
                    ptr[8]   <= shreg[1];
                    sda_oe_b <= 1'b0;
                    state    <= ST_RXACK;
                  end else begin
                    state <= ST_IDLE;
                  end
                end
                K_ADDR: begin
                  ptr[7:0] <= shreg;
                  sda_oe_b <= 1'b0;
                  state    <= ST_RXACK;
                end
                default: begin
                  // Low bits only; roll-over stays in page
                  ptr[3:0] <= ptr[3:0] + 4'h1;
                  pend     <= 1'b1;
                  sda_oe_b <= 1'b0;
                  state    <= ST_RXACK;
                end
              endcase
            end
          end
          ST_RXACK: begin
            // Held low until the ninth clock falls
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (kind == K_CTRL && rw) begin
                shreg    <= tx_byte;
                ptr      <= ptr + 9'h001;
                sda_oe_b <= tx_byte[7];
                state    <= ST_TX;
              end else begin
                sda_oe_b <= 1'b1;
                kind     <= (kind == K_CTRL) ? K_ADDR : K_DATA;
                state    <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                sda_oe_b <= 1'b1;
                state    <= ST_TXACK;
              end else begin
                sda_oe_b <= shreg[6];
                shreg    <= {shreg[6:0], 1'b1};
              end
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          ST_TXACK: begin
            // Host level on the ninth rise decides: stop or next byte
            if (scl_rise) begin
              if (ln_s2.sda) begin
                state <= ST_IDLE;
              end else begin
                bit_cnt <= 4'h8;
              end
            end else if (scl_fall && bit_cnt == 4'h8) begin
              shreg    <= tx_byte;
              ptr      <= ptr + 9'h001;
              sda_oe_b <= tx_byte[7];
              bit_cnt  <= 4'h0;
              state    <= ST_TX;
            end
          end
          default: begin
            state    <= ST_IDLE;
            sda_oe_b <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Page buffer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask <= '0;
      for (int i = 0; i < PAGE_SIZE; i++) begin
        pbuf[i] <= 8'h00;
      end
    end else if (ce) begin
      if (rx_done && ctrl_ok && !shreg[0]) begin
        mask <= '0;
      end else if (data_take) begin
        pbuf[ptr[3:0]] <= shreg;
        mask[ptr[3:0]] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Array, committed only after Stop and only when unprotected
  // Protected writes still start the timer, so polling looks the same
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem[i] <= MEM_INIT;
      end
    end else if (ce && commit && !wp_s2) begin
      for (int i = 0; i < PAGE_SIZE; i++) begin
        if (mask[i]) begin
          mem[{ptr[8:4], i[3:0]}] <= pbuf[i];
        end
      end
    end
  end

  // ==========================================================================
  // Internal write cycle timer
  // A commit outranks expiry, restarting the full count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy     <= 1'b0;
      busy_cnt <= '0;
    end else if (ce) begin
      if (commit) begin
        busy     <= 1'b1;
        busy_cnt <= CW'(TWC_CYCLES - 1);
      end else if (busy) begin
        if (busy_cnt == '0) begin
          busy <= 1'b0;
        end else begin
          busy_cnt <= busy_cnt - CW'(1);
        end
      end
    end
  end

  // ==========================================================================
  // APB slave
  function automatic logic [31:0] stat_word();
    logic [31:0] w;
    w = '0;
    w[STAT_BUSY_BIT] = busy;
    w[STAT_WP_BIT]   = wp_s2;
    w[STAT_PEND_BIT] = pend;
    w[STAT_PTR_LSB +: 9] = ptr;
    return w;
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      // One wait state: the answer follows the first access edge
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= 32'h0000_0000;
        unique case (paddr)
          REG_CTRL: begin
            if (!pwrite) begin
              prdata[CTRL_RESP_BIT] <= resp_en;
            end
          end
          REG_STAT: begin
            pslverr <= pwrite;
            if (!pwrite) begin
              prdata <= stat_word();
            end
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Control register, written on the edge that completes the access
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_en <= CTRL_RESP_RST;
    end else if (ce) begin
      if (psel && penable && pready && pwrite && (paddr == REG_CTRL)) begin
        resp_en <= pwdata[CTRL_RESP_BIT];
      end
    end
  end

  // ==========================================================================
  // Open-drain data value; only the enable ever moves
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_o <= 1'b0;
    end else if (ce) begin
      sda_o <= 1'b0;
    end
  end

endmodule

/* File: ee_pkg.sv */
// Shared constants, types and register map of the two-wire EEPROM client
package ee_pkg;

  // ==========================================================================
  // Clock and write cycle timing
  localparam int unsigned CLK_HZ  = 100_000_000;
  localparam int unsigned TWC_MS  = 5;
  localparam int unsigned TWC_CYC = (CLK_HZ / 1000) * TWC_MS;

  // ==========================================================================
  // Array geometry and contents
  localparam int unsigned MEM_WORDS = 512;
  localparam int unsigned PAGE_SIZE = 16;
  localparam logic [7:0]  MEM_INIT  = 8'hff;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_STAT       = 8'h04;
  localparam int unsigned CTRL_RESP_BIT  = 0;
  localparam logic        CTRL_RESP_RST  = 1'b1;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_WP_BIT    = 1;
  localparam int unsigned STAT_PEND_BIT  = 2;
  localparam int unsigned STAT_PTR_LSB   = 4;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RX    = 3'h1,
    ST_RXACK = 3'h3,
    ST_TX    = 3'h2,
    ST_TXACK = 3'h6
  } ee_state_e;

  typedef enum logic [1:0] {
    K_CTRL = 2'h0,
    K_ADDR = 2'h1,
    K_DATA = 2'h3
  } ee_kind_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } ee_line_s;

endpackage

/* File: ee_host.sv */
// Two-wire bus host model that drives SCL and frames every transfer
`timescale 1ns/1ps

module ee_host (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_d
);
  // Both lines idle high until the first frame
  initial begin
    scl = 1'b1;
    sda_d = 1'b1;
  end

  task automatic q;
    repeat (2) @(posedge clk);
  endtask

  task automatic start;
    sda_d <= 1'b1;
    q;
    scl <= 1'b1;
    q;
    sda_d <= 1'b0;
    q;
    scl <= 1'b0;
    q;
  endtask

  task automatic stop;
    sda_d <= 1'b0;
    q;
    scl <= 1'b1;
    q;
    sda_d <= 1'b1;
    q;
  endtask

  // Data set mid low phase, sampled mid high phase
  task automatic bit_x(input logic b, output logic r);
    sda_d <= b;
    q;
    scl <= 1'b1;
    q;
    r = sda;
    q;
    scl <= 1'b0;
    q;
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask

  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      b[i] = r;
    end
    bit_x(last, r);
  endtask
endmodule

/* File: ee_props.sv */
// Assertions on the ports of the two-wire EEPROM client
`timescale 1ns/1ps

module ee_props (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_b
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_drain_low: assert property (!sda_oe_b |-> !sda_o && !sda_i)
    else $error("sda not low while driven");
  a_edge_scl_low: assert property ($changed(sda_oe_b) |-> !scl_i)
    else $error("sda drive changed with scl high");
  a_start_quiet: assert property (scl_i && $fell(sda_i) |=> sda_oe_b [*8])
    else $error("sda driven right after start");
  a_stop_quiet: assert property (scl_i && $rose(sda_i) |=> sda_oe_b [*8])
    else $error("sda driven right after stop");
  a_drive_hold: assert property ($fell(sda_oe_b) |=> !sda_oe_b [*7])
    else $error("sda drive too short");
  a_drive_ends: assert property ($fell(sda_oe_b) |-> ##[1:200] sda_oe_b)
    else $error("sda never released");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_answer: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("prdata not zero on write");
endmodule

bind ee_i2c_client ee_props u_props (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_b(sda_oe_b));

/* File: tb.sv */
// Self-checking bench for the two-wire EEPROM client
`timescale 1ns/1ps

module tb;
  import ee_pkg::*;
  localparam int unsigned TWC  = 200;
  localparam logic [3:0]  CODE = 4'h6;  // Arbitrary value
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl;
  logic        sda_d;
  logic        sda_o;
  logic        sda_oe_b;
  logic        wp = 1'b0;
  logic [2:0]  upin = 3'h0;
  wire         sda;
  logic [7:0]  mem [512];
  logic [8:0]  p;
  int          err_total;
  int          num_checks;

  // Open-drain wire with pull-up
  assign sda = sda_d & (sda_oe_b | sda_o);
  always #5 clk = ~clk;

  ee_i2c_client #(.TWC_CYCLES(TWC), .DEV_CODE(CODE)) DUT (
    .clk(clk), .rst_b(rst_b), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_b(sda_oe_b), .wp(wp),
    .unused_addr_pin_0(upin[0]), .unused_addr_pin_1(upin[1]), .unused_addr_pin_2(upin[2]));
  ee_host host (.clk(clk), .sda(sda), .scl(scl), .sda_d(sda_d));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [8:0] a, input int n, input logic [7:0] d0);
    logic k;
    logic ok;
    host.start;
    host.wbyte({CODE, 2'b10, a[8], 1'b0}, ok);
    host.wbyte(a[7:0], k);
    ok &= k;
    for (int i = 0; i < n; i++) begin
      host.wbyte(d0 + 8'(i), k);
      ok &= k;
      if (!wp) mem[{a[8:4], a[3:0] + 4'(i)}] = d0 + 8'(i);
    end
    host.stop;
    p = {a[8:4], a[3:0] + 4'(n)};
    chk(ok, 1'b1, "write ack");
  endtask

  task automatic rd(input logic rnd, input logic [8:0] a, input int n);
    logic k;
    logic [7:0] b;
    if (rnd) begin
      host.start;
      host.wbyte({CODE, 2'b01, a[8], 1'b0}, k);
      host.wbyte(a[7:0], k);
      p = a;
    end
    host.start;
    host.wbyte({CODE, 2'b11, p[8], 1'b1}, k);
    chk(k, 1'b1, "read ack");
    for (int i = 0; i < n; i++) begin
      host.rbyte(i == n - 1, b);
      chk(b, mem[p], "read data");
      p++;
    end
    host.stop;
  endtask

  task automatic poll;
    logic k;
    int n;
    n = 0;
    k = 1'b0;
    while (!k && n < 30) begin
      host.start;
      host.wbyte({CODE, 3'b000, 1'b0}, k);
      host.stop;
      n++;
    end
    chk(n > 1 && k, 1'b1, "busy polling");
  endtask

  task automatic s_regs;
    logic [31:0] r;
    logic e;
    apb(1'b0, REG_CTRL, 32'h0, r, e);
    chk({r[0], e}, {CTRL_RESP_RST, 1'b0}, "ctrl reset");
    apb(1'b1, REG_STAT, 32'h0, r, e);
    chk(e, 1'b1, "stat write");
    apb(1'b0, 8'h08, 32'h0, r, e);
    chk(e, 1'b1, "unmapped");
  endtask

  task automatic s_addr;
    logic [31:0] r;
    logic e;
    logic k;
    apb(1'b1, REG_CTRL, 32'h0, r, e);
    host.start;
    host.wbyte({CODE, 4'h0}, k);
    host.stop;
    chk(k, 1'b0, "response disabled");
    apb(1'b1, REG_CTRL, 32'h1, r, e);
    upin <= 3'h7;
    host.start;
    host.wbyte({~CODE, 4'h0}, k);
    chk(k, 1'b0, "foreign code");
    host.wbyte(8'h00, k);
    chk(k, 1'b0, "ignored after mismatch");
    host.stop;
  endtask

  task automatic s_page;
    logic [31:0] r;
    logic e;
    wr(9'h1f8, 18, 8'h40);
    repeat (4) @(posedge clk);
    apb(1'b0, REG_STAT, 32'h0, r, e);
    chk(r[STAT_BUSY_BIT], 1'b1, "busy after stop");
    poll;
    rd(1'b1, 9'h1f0, 16);
    rd(1'b0, 9'h000, 1);
  endtask

  task automatic s_wp;
    logic [31:0] r;
    logic e;
    wp <= 1'b1;
    wr(9'h005, 1, 8'h3c);
    poll;
    rd(1'b1, 9'h005, 1);
    apb(1'b0, REG_STAT, 32'h0, r, e);
    chk(r[STAT_WP_BIT], 1'b1, "wp status");
    chk(r[STAT_PTR_LSB +: 9], p, "pointer");
    wp <= 1'b0;
    wr(9'h105, 1, 8'h5a);
    poll;
    rd(1'b1, 9'h104, 3);
  endtask

  task automatic s_reset;
    logic [31:0] r;
    logic e;
    apb(1'b1, REG_CTRL, 32'h0, r, e);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    foreach (mem[i]) mem[i] = MEM_INIT;
    apb(1'b0, REG_CTRL, 32'h0, r, e);
    chk(r[CTRL_RESP_BIT], CTRL_RESP_RST, "ctrl after reset");
    rd(1'b1, 9'h105, 1);
  endtask

  task automatic stop_test;
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    foreach (mem[i]) mem[i] = MEM_INIT;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    s_regs;
    s_addr;
    s_page;
    s_wp;
    s_reset;
    stop_test;
  end

  initial begin
    #400us;
    err_total++;
    stop_test;
  end
endmodule
